// ==== logic/pic_flag_bank.sv ====
// sticky factor flags, write one to clear, set beats clear
module pic_flag_bank
  import pic_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
)
(
  input  wire logic clk,  // system clock
  input  wire logic rst,  // async reset, active high
  input  wire logic ce,   // clock enable
  pic_flag_if.bank  fb    // flag port
);

  logic [7:0] flag_q;
  logic [7:0] flag_d;

  // ************************************************************
  // flag update
  // ************************************************************
  // an event in the clearing cycle must survive, so set is or-ed last
  always_comb
  begin
    flag_d = flag_q;
    if (fb.wr_clr)
      flag_d = flag_d & ~fb.wr_data;
    flag_d = (flag_d | fb.set_ev) & MASK;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_q <= PIC_RST_VAL;
    else if (ce)
      flag_q <= flag_d;
  end

  assign fb.flags = flag_q;

  property p_set_wins;
    @(posedge clk) disable iff (rst)
      ce && (|(fb.set_ev & MASK)) |=> ((flag_q & $past(fb.set_ev) & MASK) == ($past(fb.set_ev) & MASK));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag event lost");

  property p_w1c;
    @(posedge clk) disable iff (rst)
      ce && fb.wr_clr && ((fb.set_ev & fb.wr_data) == 8'h00)
        |=> ((flag_q & $past(fb.wr_data)) == 8'h00);
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_unused_zero;
    @(posedge clk) disable iff (rst) (flag_q & ~MASK) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused flag bit set");

endmodule

// ==== logic/pic_flag_if.sv ====
// carries one flag register's events, clear write and state between the top and a flag bank
interface pic_flag_if;
  logic [7:0] set_ev;   // hardware event pulses
  logic       wr_clr;   // write strobe to the flag address
  logic [7:0] wr_data;  // written byte, ones clear
  logic [7:0] flags;    // current flag state
  modport bank (input set_ev, input wr_clr, input wr_data, output flags);
  modport ctrl (output set_ev, output wr_clr, output wr_data, input flags);
endinterface

// ==== logic/pic_pkg.sv ====
package pic_pkg;

  // ************************************************************
  // register map (byte addresses on the i/o bus)
  // ************************************************************
  localparam logic [15:0] PIC_ADR_PRIO_A    = 16'hff20;
  localparam logic [15:0] PIC_ADR_PRIO_B    = 16'hff21;
  localparam logic [15:0] PIC_ADR_EN_TB     = 16'hff22;
  localparam logic [15:0] PIC_ADR_EN_SER    = 16'hff23;
  localparam logic [15:0] PIC_ADR_EN_KEY    = 16'hff24;
  localparam logic [15:0] PIC_ADR_EN_TLO    = 16'hff25;
  localparam logic [15:0] PIC_ADR_FL_TB     = 16'hff26;
  localparam logic [15:0] PIC_ADR_FL_SER    = 16'hff27;
  localparam logic [15:0] PIC_ADR_FL_KEY    = 16'hff28;
  localparam logic [15:0] PIC_ADR_FL_TLO    = 16'hff29;
  localparam logic [15:0] PIC_ADR_PRIO_C    = 16'hff2a;
  localparam logic [15:0] PIC_ADR_EN_THI    = 16'hff2c;
  localparam logic [15:0] PIC_ADR_FL_THI    = 16'hff2e;
  localparam logic [15:0] PIC_ADR_CPU_MODE  = 16'hff00;
  localparam logic [15:0] PIC_ADR_STK_PAGE  = 16'hff01;

  // ************************************************************
  // implemented-bit masks; other bits read zero
  // ************************************************************
  localparam logic [7:0] PIC_MASK_FULL  = 8'hff;
  localparam logic [7:0] PIC_MASK_PRB   = 8'h3f;
  localparam logic [7:0] PIC_MASK_TB    = 8'h7f;
  localparam logic [7:0] PIC_MASK_SER   = 8'h3f;
  localparam logic [7:0] PIC_MASK_PRC   = 8'h0f;
  localparam logic [7:0] PIC_RST_VAL    = 8'h00;

  // ************************************************************
  // field positions in the priority registers
  // ************************************************************
  localparam int PIC_POS_TICK   = 0;  // prio a
  localparam int PIC_POS_STOPW  = 2;
  localparam int PIC_POS_SER0   = 4;
  localparam int PIC_POS_KEY    = 6;
  localparam int PIC_POS_SER1   = 0;  // prio b
  localparam int PIC_POS_TMR10  = 2;
  localparam int PIC_POS_TMR32  = 4;
  localparam int PIC_POS_TMR54  = 0;  // prio c
  localparam int PIC_POS_TMR76  = 2;

  // request groups, in fixed order of the request output vector
  localparam int PIC_NGRP = 9;

endpackage

// ==== logic/pic_top.sv ====
// Function
// - clock timer has flags for 32, 8, 2 and 1 Hz intervals.
// - stopwatch has flags for 100, 10 and 1 Hz intervals.
// - each serial channel has error, receive and transmit flags.
// - eight key line flags packed in one register.
// - timers 0-3 have underflow (even bit) and compare flags.
// - flags read one when set, write one clears, zero after reset.
// - priority fields are two bits, value equals level, reset zero.
// - key lines share one priority field in the top two bits.
// - stopwatch and clock timer priority fields in low bits of first register.
// - serial channel 1 has its own priority field for all causes.
// - timers 3-2 and 1-0 share priority fields in pairs.
// - timers 7-6 and 5-4 share fields; upper nibble reads zero.
// - each clock and stopwatch interval has an enable, reset zero.
// - each serial cause has an enable bit, reset zero.
// - each timer 0-3 underflow and compare has an enable.
// - timers 4-7 causes have enables in a dedicated register.
// - timers 4-7 flags sit in their own register, write one clears.
// - all interrupts blocked until mode and stack page registers written.
module pic_top
  import pic_pkg::*;
(
  input  wire logic        clk,         // system clock, 25 MHz
  input  wire logic        rst,         // async reset, active high
  input  wire logic        ce,          // clock enable, freezes state when low
  input  wire logic [15:0] addr,        // i/o address
  input  wire logic        wr,          // write strobe, one cycle
  input  wire logic        rd,          // read strobe
  input  wire logic [7:0]  wdata,       // write data
  output logic      [7:0]  rdata,       // registered read data
  input  wire logic [3:0]  tick_ev,     // clock timer 1,2,8,32 Hz events
  input  wire logic [2:0]  stopw_ev,    // stopwatch 1,10,100 Hz events
  input  wire logic [5:0]  ser_ev,      // serial causes, flag-register order
  input  wire logic [7:0]  key_ev,      // key input line events
  input  wire logic [7:0]  tmr_lo_ev,   // timers 0-3 under/match events
  input  wire logic [7:0]  tmr_hi_ev,   // timers 4-7 under/match events
  output logic             irq,         // an enabled request is pending
  output logic      [1:0]  irq_level,   // highest level among pending groups
  output logic      [8:0]  grp_req      // per-group pending request
);

  // ************************************************************
  // register storage
  // ************************************************************
  logic [7:0] prio_a_q;
  logic [7:0] prio_b_q;
  logic [7:0] prio_c_q;
  logic [7:0] en_tb_q;
  logic [7:0] en_ser_q;
  logic [7:0] en_key_q;
  logic [7:0] en_tlo_q;
  logic [7:0] en_thi_q;
  logic       mode_seen_q;
  logic       page_seen_q;
  logic       unlock;
  logic [7:0] rdata_d;

  pic_flag_if f_tb ();
  pic_flag_if f_ser ();
  pic_flag_if f_key ();
  pic_flag_if f_tlo ();
  pic_flag_if f_thi ();

  function automatic logic hit(input logic [15:0] a);
    hit = wr && (addr == a);
  endfunction

  // ************************************************************
  // priority registers
  // ************************************************************
  // unused bits are masked at write time so they can never hold a one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prio_a_q <= PIC_RST_VAL;
      prio_b_q <= PIC_RST_VAL;
      prio_c_q <= PIC_RST_VAL;
    end
    else if (ce)
    begin
      if (hit(PIC_ADR_PRIO_A))
        prio_a_q <= wdata;
      if (hit(PIC_ADR_PRIO_B))
        prio_b_q <= wdata & PIC_MASK_PRB;
      if (hit(PIC_ADR_PRIO_C))
        prio_c_q <= wdata & PIC_MASK_PRC;
    end
  end

  // ************************************************************
  // enable registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      en_tb_q  <= PIC_RST_VAL;
      en_ser_q <= PIC_RST_VAL;
      en_key_q <= PIC_RST_VAL;
      en_tlo_q <= PIC_RST_VAL;
      en_thi_q <= PIC_RST_VAL;
    end
    else if (ce)
    begin
      if (hit(PIC_ADR_EN_TB))
        en_tb_q <= wdata & PIC_MASK_TB;
      if (hit(PIC_ADR_EN_SER))
        en_ser_q <= wdata & PIC_MASK_SER;
      if (hit(PIC_ADR_EN_KEY))
        en_key_q <= wdata;
      if (hit(PIC_ADR_EN_TLO))
        en_tlo_q <= wdata;
      if (hit(PIC_ADR_EN_THI))
        en_thi_q <= wdata;
    end
  end

  // ************************************************************
  // unlock after reset
  // ************************************************************
  // the two cpu registers live elsewhere; we only watch their writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_seen_q <= 1'b0;
      page_seen_q <= 1'b0;
    end
    else if (ce)
    begin
      if (hit(PIC_ADR_CPU_MODE))
        mode_seen_q <= 1'b1;
      if (hit(PIC_ADR_STK_PAGE))
        page_seen_q <= 1'b1;
    end
  end

  assign unlock = mode_seen_q && page_seen_q;

  // ************************************************************
  // flag banks
  // ************************************************************
  // event bit order follows the flag register layout
  assign f_tb.set_ev  = {1'b0, stopw_ev[2], stopw_ev[1], stopw_ev[0],
                         tick_ev[3], tick_ev[2], tick_ev[1], tick_ev[0]};
  assign f_ser.set_ev = {2'b00, ser_ev};
  assign f_key.set_ev = key_ev;
  assign f_tlo.set_ev = tmr_lo_ev;
  assign f_thi.set_ev = tmr_hi_ev;

  // spelled out: a continuous assign only wakes on its operands, not on what a function reads
  assign f_tb.wr_clr  = wr && (addr == PIC_ADR_FL_TB);
  assign f_ser.wr_clr = wr && (addr == PIC_ADR_FL_SER);
  assign f_key.wr_clr = wr && (addr == PIC_ADR_FL_KEY);
  assign f_tlo.wr_clr = wr && (addr == PIC_ADR_FL_TLO);
  assign f_thi.wr_clr = wr && (addr == PIC_ADR_FL_THI);

  assign f_tb.wr_data  = wdata;
  assign f_ser.wr_data = wdata;
  assign f_key.wr_data = wdata;
  assign f_tlo.wr_data = wdata;
  assign f_thi.wr_data = wdata;

  pic_flag_bank #(.MASK(PIC_MASK_TB))   u_fl_tb  (.clk(clk), .rst(rst), .ce(ce), .fb(f_tb));
  pic_flag_bank #(.MASK(PIC_MASK_SER))  u_fl_ser (.clk(clk), .rst(rst), .ce(ce), .fb(f_ser));
  pic_flag_bank #(.MASK(PIC_MASK_FULL)) u_fl_key (.clk(clk), .rst(rst), .ce(ce), .fb(f_key));
  pic_flag_bank #(.MASK(PIC_MASK_FULL)) u_fl_tlo (.clk(clk), .rst(rst), .ce(ce), .fb(f_tlo));
  pic_flag_bank #(.MASK(PIC_MASK_FULL)) u_fl_thi (.clk(clk), .rst(rst), .ce(ce), .fb(f_thi));

  // ************************************************************
  // read mux
  // ************************************************************
  // unmapped addresses read zero; read data is registered
  always_comb
  begin
    unique case (addr)
      PIC_ADR_PRIO_A: rdata_d = prio_a_q;
      PIC_ADR_PRIO_B: rdata_d = prio_b_q;
      PIC_ADR_PRIO_C: rdata_d = prio_c_q;
      PIC_ADR_EN_TB:  rdata_d = en_tb_q;
      PIC_ADR_EN_SER: rdata_d = en_ser_q;
      PIC_ADR_EN_KEY: rdata_d = en_key_q;
      PIC_ADR_EN_TLO: rdata_d = en_tlo_q;
      PIC_ADR_EN_THI: rdata_d = en_thi_q;
      PIC_ADR_FL_TB:  rdata_d = f_tb.flags;
      PIC_ADR_FL_SER: rdata_d = f_ser.flags;
      PIC_ADR_FL_KEY: rdata_d = f_key.flags;
      PIC_ADR_FL_TLO: rdata_d = f_tlo.flags;
      PIC_ADR_FL_THI: rdata_d = f_thi.flags;
      default:        rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (ce && rd)
      rdata <= rdata_d;
  end

  // ************************************************************
  // request generation
  // ************************************************************
  // groups: 0 tick, 1 stopw, 2 ser0, 3 ser1, 4 key, 5 tmr10, 6 tmr32, 7 tmr54, 8 tmr76
  logic [8:0]       pend;
  logic [1:0]       lvl [PIC_NGRP];
  logic [7:0]       act_tb;
  logic [7:0]       act_ser;
  logic [7:0]       act_tlo;
  logic [7:0]       act_thi;

  assign act_tb  = f_tb.flags  & en_tb_q;
  assign act_ser = f_ser.flags & en_ser_q;
  assign act_tlo = f_tlo.flags & en_tlo_q;
  assign act_thi = f_thi.flags & en_thi_q;

  assign pend[0] = |act_tb[3:0];
  assign pend[1] = |act_tb[6:4];
  assign pend[2] = |act_ser[2:0];
  assign pend[3] = |act_ser[5:3];
  assign pend[4] = |(f_key.flags & en_key_q);
  assign pend[5] = |act_tlo[3:0];
  assign pend[6] = |act_tlo[7:4];
  assign pend[7] = |act_thi[3:0];
  assign pend[8] = |act_thi[7:4];

  assign lvl[0] = prio_a_q[PIC_POS_TICK  +: 2];
  assign lvl[1] = prio_a_q[PIC_POS_STOPW +: 2];
  assign lvl[2] = prio_a_q[PIC_POS_SER0  +: 2];
  assign lvl[3] = prio_b_q[PIC_POS_SER1  +: 2];
  assign lvl[4] = prio_a_q[PIC_POS_KEY   +: 2];
  assign lvl[5] = prio_b_q[PIC_POS_TMR10 +: 2];
  assign lvl[6] = prio_b_q[PIC_POS_TMR32 +: 2];
  assign lvl[7] = prio_c_q[PIC_POS_TMR54 +: 2];
  assign lvl[8] = prio_c_q[PIC_POS_TMR76 +: 2];

  // highest level wins; a level field of zero still requests (cpu masks it)
  always_comb
  begin
    irq_level = 2'b00;
    for (int g = 0; g < PIC_NGRP; g++)
      if (pend[g] && unlock && (lvl[g] > irq_level))
        irq_level = lvl[g];
  end

  assign grp_req = unlock ? pend : 9'h000;
  assign irq     = |grp_req;

  // ************************************************************
  // checks
  // ************************************************************
  property p_locked;
    @(posedge clk) disable iff (rst) !unlock |-> !irq && (grp_req == 9'h000);
  endproperty
  a_locked: assert property (p_locked) else $error("request before unlock");

  property p_req_cause;
    @(posedge clk) disable iff (rst) grp_req[4] |-> |(f_key.flags & en_key_q);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("key request without enabled flag");

  sequence s_prio_write;
    ce && wr && (addr == PIC_ADR_PRIO_C);
  endsequence
  property p_prio_c_hi;
    @(posedge clk) disable iff (rst) s_prio_write |=> prio_c_q[7:4] == 4'h0;
  endproperty
  a_prio_c_hi: assert property (p_prio_c_hi) else $error("timer prio upper nibble set");

  property p_level_max;
    @(posedge clk) disable iff (rst) unlock && pend[4] |-> irq_level >= lvl[4];
  endproperty
  a_level_max: assert property (p_level_max) else $error("key level not honoured");

  property p_en_ser_hi;
    @(posedge clk) disable iff (rst) en_ser_q[7:6] == 2'b00 && en_tb_q[7] == 1'b0;
  endproperty
  a_en_ser_hi: assert property (p_en_ser_hi) else $error("unused enable bit set");

  // one bus write as seen at its taking edge
  sequence s_wr(logic [15:0] a);
    ce && wr && (addr == a);
  endsequence

  property p_prio_a_wr;
    @(posedge clk) disable iff (rst) s_wr(PIC_ADR_PRIO_A) |=> prio_a_q == $past(wdata);
  endproperty
  a_prio_a_wr: assert property (p_prio_a_wr) else $error("priority a write lost");

  property p_prio_b_wr;
    @(posedge clk) disable iff (rst) s_wr(PIC_ADR_PRIO_B) |=> prio_b_q == ($past(wdata) & PIC_MASK_PRB);
  endproperty
  a_prio_b_wr: assert property (p_prio_b_wr) else $error("priority b write wrong");

  property p_en_tb_wr;
    @(posedge clk) disable iff (rst) s_wr(PIC_ADR_EN_TB) |=> en_tb_q == ($past(wdata) & PIC_MASK_TB);
  endproperty
  a_en_tb_wr: assert property (p_en_tb_wr) else $error("timebase enable write wrong");

  property p_en_ser_wr;
    @(posedge clk) disable iff (rst) s_wr(PIC_ADR_EN_SER) |=> en_ser_q == ($past(wdata) & PIC_MASK_SER);
  endproperty
  a_en_ser_wr: assert property (p_en_ser_wr) else $error("serial enable write wrong");

  property p_en_tlo_wr;
    @(posedge clk) disable iff (rst) s_wr(PIC_ADR_EN_TLO) |=> en_tlo_q == $past(wdata);
  endproperty
  a_en_tlo_wr: assert property (p_en_tlo_wr) else $error("low timer enable write lost");

  property p_en_thi_wr;
    @(posedge clk) disable iff (rst) s_wr(PIC_ADR_EN_THI) |=> en_thi_q == $past(wdata);
  endproperty
  a_en_thi_wr: assert property (p_en_thi_wr) else $error("high timer enable write lost");

  // once both boot writes are seen, requests stay open until the next reset
  property p_unlock_sticky;
    @(posedge clk) disable iff (rst) unlock |=> unlock;
  endproperty
  a_unlock_sticky: assert property (p_unlock_sticky) else $error("unlock dropped");

  property p_unlock_pair;
    @(posedge clk) disable iff (rst) s_wr(PIC_ADR_STK_PAGE) ##0 mode_seen_q |=> unlock;
  endproperty
  a_unlock_pair: assert property (p_unlock_pair) else $error("boot writes did not unlock");

  // clock enable low must leave priority a, the key enable and the key flags as they were
  property p_freeze;
    @(posedge clk) disable iff (rst) !ce |=> $stable(prio_a_q) && $stable(en_key_q) && $stable(f_key.flags);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  property p_rdata_hold;
    @(posedge clk) disable iff (rst) !(ce && rd) |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

  property p_flag_read;
    @(posedge clk) disable iff (rst) ce && rd && (addr == PIC_ADR_FL_KEY) |=> rdata == $past(f_key.flags);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("key flag read wrong");

  property p_idle_level;
    @(posedge clk) disable iff (rst) !irq |-> irq_level == 2'b00;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("level shown without request");

endmodule

// ==== tb/pic_cpu_model.sv ====
// cpu core side of the i/o bus: one transfer per read or write call, strobes driven off the falling edge
module pic_cpu_model
  import pic_pkg::*;
(
  input  wire logic        clk,    // system clock
  input  wire logic [7:0]  rdata,  // read data from the block
  output logic      [15:0] addr,   // i/o address
  output logic             wr,     // write strobe
  output logic             rd,     // read strobe
  output logic      [7:0]  wdata   // write data
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle at time zero
  initial
  begin
    addr  = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
    wdata = 8'h00;
  end

  // held across the taking edge; released data is inverted so no stale byte lingers
  task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
    wdata = ~d;
  endtask

  // rdata is registered by the edge that takes rd, so it is ready one half cycle later
  task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d  = rdata;
  endtask

  // boot writes of mode and stack page; until both land no request may reach the core
  task automatic unlock();
    write_reg(PIC_ADR_CPU_MODE, 8'h80);
    write_reg(PIC_ADR_STK_PAGE, 8'h01);
  endtask
endmodule

// ==== tb/tb_peripheral_interrupt_control.sv ====
module tb_peripheral_interrupt_control
  import pic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, ce, wr, rd, irq;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, key_ev, tmr_lo_ev, tmr_hi_ev, d;
  logic [3:0]  tick_ev;
  logic [2:0]  stopw_ev;
  logic [5:0]  ser_ev;
  logic [1:0]  irq_level, lvl;
  logic [8:0]  grp_req;
  int          mismatches, cmp_count;

  // ****************************************
  // register tables
  // ****************************************
  localparam logic [15:0] FL_ADR [5] = '{PIC_ADR_FL_TB, PIC_ADR_FL_SER, PIC_ADR_FL_KEY, PIC_ADR_FL_TLO, PIC_ADR_FL_THI};
  localparam logic [7:0]  FL_MSK [5] = '{PIC_MASK_TB, PIC_MASK_SER, PIC_MASK_FULL, PIC_MASK_FULL, PIC_MASK_FULL};
  localparam logic [15:0] EN_ADR [5] = '{PIC_ADR_EN_TB, PIC_ADR_EN_SER, PIC_ADR_EN_KEY, PIC_ADR_EN_TLO, PIC_ADR_EN_THI};
  localparam logic [15:0] RW_ADR [8] = '{PIC_ADR_PRIO_A, PIC_ADR_PRIO_B, PIC_ADR_EN_TB, PIC_ADR_EN_SER,
                                         PIC_ADR_EN_KEY, PIC_ADR_EN_TLO, PIC_ADR_PRIO_C, PIC_ADR_EN_THI};
  localparam logic [7:0]  RW_MSK [8] = '{PIC_MASK_FULL, PIC_MASK_PRB, PIC_MASK_TB, PIC_MASK_SER,
                                         PIC_MASK_FULL, PIC_MASK_FULL, PIC_MASK_PRC, PIC_MASK_FULL};
  // per request group: flag register index, source bit, priority register, field position
  localparam int          G_REG [9] = '{0, 0, 1, 1, 2, 3, 3, 4, 4};
  localparam int          G_BIT [9] = '{0, 4, 0, 3, 0, 0, 4, 0, 4};
  localparam logic [15:0] G_PAD [9] = '{PIC_ADR_PRIO_A, PIC_ADR_PRIO_A, PIC_ADR_PRIO_A, PIC_ADR_PRIO_B,
                                        PIC_ADR_PRIO_A, PIC_ADR_PRIO_B, PIC_ADR_PRIO_B, PIC_ADR_PRIO_C, PIC_ADR_PRIO_C};
  localparam int          G_POS [9] = '{PIC_POS_TICK, PIC_POS_STOPW, PIC_POS_SER0, PIC_POS_SER1, PIC_POS_KEY,
                                        PIC_POS_TMR10, PIC_POS_TMR32, PIC_POS_TMR54, PIC_POS_TMR76};

  pic_top pic_top_i (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata),
    .tick_ev(tick_ev), .stopw_ev(stopw_ev), .ser_ev(ser_ev), .key_ev(key_ev), .tmr_lo_ev(tmr_lo_ev),
    .tmr_hi_ev(tmr_hi_ev), .irq(irq), .irq_level(irq_level), .grp_req(grp_req));

  pic_cpu_model pic_cpu_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata));

  // 25 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    pic_cpu_model_i.read_reg(a, d);
    check({1'b0, d}, {1'b0, exp});
  endtask

  // one-cycle event pulse into the source group that feeds flag register r
  task automatic pulse(input int r, input logic [7:0] v);
    @(negedge clk);
    case (r)
      0: {stopw_ev, tick_ev} = v[6:0];
      1: ser_ev = v[5:0];
      2: key_ev = v;
      3: tmr_lo_ev = v;
      default: tmr_hi_ev = v;
    endcase
    @(negedge clk);
    {stopw_ev, tick_ev, ser_ev} = 13'h0000;
    key_ev    = 8'h00;
    tmr_lo_ev = 8'h00;
    tmr_hi_ev = 8'h00;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, far beyond the roughly 750 cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    {rst, ce, stopw_ev, tick_ev, ser_ev} = 15'h6000;
    {key_ev, tmr_lo_ev, tmr_hi_ev} = 24'h000000;
    mismatches = 0;
    cmp_count  = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // every register starts cleared
    for (int i = 0; i < 8; i++) rd_chk(RW_ADR[i], 8'h00);
    for (int i = 0; i < 5; i++) rd_chk(FL_ADR[i], 8'h00);
    // a pending enabled source is held back until both boot registers are written
    pic_cpu_model_i.write_reg(PIC_ADR_EN_KEY, 8'h01);
    pulse(2, 8'h01);
    check({8'h00, irq}, 9'h000);
    pic_cpu_model_i.unlock();
    check({8'h00, irq}, 9'h001);
    pic_cpu_model_i.write_reg(PIC_ADR_FL_KEY, 8'h00);
    rd_chk(PIC_ADR_FL_KEY, 8'h01);
    pic_cpu_model_i.write_reg(PIC_ADR_FL_KEY, 8'h01);
    check({8'h00, irq}, 9'h000);
    // implemented bits only, and unmapped holes stay silent
    for (int i = 0; i < 8; i++)
    begin
      pic_cpu_model_i.write_reg(RW_ADR[i], 8'hff);
      rd_chk(RW_ADR[i], RW_MSK[i]);
      pic_cpu_model_i.write_reg(RW_ADR[i], 8'h00);
    end
    pic_cpu_model_i.write_reg(16'hff2b, 8'hff);
    rd_chk(16'hff2b, 8'h00);
    // walking one through every flag: set by its own event, zeros keep, ones clear
    for (int r = 0; r < 5; r++)
      for (int b = 0; b < 8; b++)
      begin
        pulse(r, 8'h01 << b);
        check(grp_req, 9'h000);
        rd_chk(FL_ADR[r], (8'h01 << b) & FL_MSK[r]);
        pic_cpu_model_i.write_reg(FL_ADR[r], ~(8'h01 << b));
        rd_chk(FL_ADR[r], (8'h01 << b) & FL_MSK[r]);
        pic_cpu_model_i.write_reg(FL_ADR[r], 8'h01 << b);
        rd_chk(FL_ADR[r], 8'h00);
      end
    // each group: request only with its own enable, carrying its own field's level
    for (int g = 0; g < 9; g++)
    begin
      lvl = 2'(g % 3 + 1);  // nonzero for every group, so a misplaced field shows
      pic_cpu_model_i.write_reg(G_PAD[g], {6'h00, lvl} << G_POS[g]);
      pic_cpu_model_i.write_reg(EN_ADR[G_REG[g]], ~(8'h01 << G_BIT[g]));
      pulse(G_REG[g], 8'h01 << G_BIT[g]);
      check(grp_req, 9'h000);
      pic_cpu_model_i.write_reg(EN_ADR[G_REG[g]], 8'h01 << G_BIT[g]);
      check(grp_req, 9'h001 << g);
      check({7'h00, irq_level}, {7'h00, lvl});
      check({8'h00, irq}, 9'h001);
      pic_cpu_model_i.write_reg(FL_ADR[G_REG[g]], 8'h01 << G_BIT[g]);
      check(grp_req, 9'h000);
      pic_cpu_model_i.write_reg(EN_ADR[G_REG[g]], 8'h00);
      pic_cpu_model_i.write_reg(G_PAD[g], 8'h00);
    end
    // two groups pending: the higher field wins, then falls back once it clears
    pic_cpu_model_i.write_reg(PIC_ADR_PRIO_A, 8'h81);
    pic_cpu_model_i.write_reg(PIC_ADR_EN_KEY, 8'h01);
    pic_cpu_model_i.write_reg(PIC_ADR_EN_TB, 8'h01);
    pulse(2, 8'h01);
    pulse(0, 8'h01);
    check(grp_req, 9'h011);
    check({7'h00, irq_level}, 9'h002);
    pic_cpu_model_i.write_reg(PIC_ADR_FL_KEY, 8'h01);
    check({7'h00, irq_level}, 9'h001);
    // clock enable low: neither an event nor a write may land
    @(negedge clk);
    ce = 1'b0;
    pulse(3, 8'h01);
    pic_cpu_model_i.write_reg(PIC_ADR_EN_TLO, 8'hff);
    ce = 1'b1;
    rd_chk(PIC_ADR_FL_TLO, 8'h00);
    rd_chk(PIC_ADR_EN_TLO, 8'h00);
    // a second reset clears everything and locks requests again until both boot writes
    check({8'h00, irq}, 9'h001);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check({8'h00, irq}, 9'h000);
    rd_chk(PIC_ADR_FL_TB, 8'h00);
    rd_chk(PIC_ADR_PRIO_A, 8'h00);
    pic_cpu_model_i.write_reg(PIC_ADR_EN_TB, 8'h01);
    pulse(0, 8'h01);
    check({8'h00, irq}, 9'h000);
    pic_cpu_model_i.write_reg(PIC_ADR_CPU_MODE, 8'h00);
    check({8'h00, irq}, 9'h000);
    pic_cpu_model_i.write_reg(PIC_ADR_STK_PAGE, 8'h00);
    check({8'h00, irq}, 9'h001);
    end_of_test();
  end
endmodule
